// File: design/dsp_pkg.sv
// Constants and types of the converter serial control port
//
// Contract
// - 24-bit frames, most significant bit first
// - Flag, unused, select, 12 data, unused
// - Sample input on falling clock, select low
// - Select high: ignore clock, output released
// - Select rising decodes and writes register
// - Under 24 edges: frame discarded
// - Over 24 edges: last 24 bits used
// - Output driven only when disable bit clear
// - Mode bit picks normal or pass-through
// - Normal: bits emerge delayed 24 clocks
// - Pass-through routes input to output directly
// - Wake pin low clears pass-through bit
// - Wake-by-select: at most one edge wakes
// - Flag one: read request, select source
// - Next frame shifts selected register out
// - Flag zero: write data to selected register
// - Unused bits ignored, read back zero
// - Load strobe low updates all latches
// - Straps caught at power-on, select high
// - Reset pin low disables the port
package dsp_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_W     = 5;
  localparam int DATA_W     = 12;
  localparam int RW_BIT     = 23;
  localparam int ADDR_HI    = 20;
  localparam int ADDR_LO    = 16;
  localparam int DATA_HI    = 15;
  localparam int DATA_LO    = 4;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_FULL  = 5'h18;
  localparam logic [CNT_W-1:0] CNT_SAT   = 5'h1f;
  localparam logic [CNT_W-1:0] WAKE_MAX  = 5'h01;
  localparam logic [ADDR_W-1:0] CFG_ADDR  = 5'h00;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 5'h06;
  localparam int CFG_SERIAL_OUT_DISABLE_BIT   = 6;
  localparam int CFG_W2_BIT     = 4;
  localparam int CFG_UNUSED_BIT = 9;
  localparam int MODE_SLEEP_BIT = 15;
  localparam logic [DATA_W-1:0] REG_RESET = 12'h000;
  localparam logic [2:0] STRAP_WAIT = 3'h5;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W     = ADDR_W + DATA_W;

  typedef enum logic [2:0] {
    ST_BOOT  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_FRAME = 3'b100
  } dsp_state_t;
endpackage

// File: design/dsp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dsp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pin side and clean level
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_next;

  assign agree      = ~(s2_reg ^ s3_reg);
  assign level_next = (agree & s3_reg) | (~agree & level_out);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg    <= RESET_VAL;
      s2_reg    <= RESET_VAL;
      s3_reg    <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= level_next;
    end
  end
endmodule // dsp_sync

// File: design/dsp_fifo.sv
// Shifting FIFO whose head sits in flip-flops
`timescale 1ns/1ns
module dsp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_shift;
  logic [DEPTH-1:0] slot;
  logic             pop;
  logic             push;

  assign pop       = vld_reg[0] & out_ready;
  assign in_ready  = ~vld_reg[DEPTH-1];
  assign push      = in_valid & in_ready;
  assign vld_shift = pop ? (vld_reg >> 1) : vld_reg;
  assign slot      = ~vld_shift & {vld_shift[DEPTH-2:0], 1'b1};
  assign out_valid = vld_reg[0];
  assign out_data  = mem_reg[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= vld_shift | (push ? slot : '0);
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (push && slot[i]) begin
        mem_reg[i] <= in_data;
      end else if (pop && i < DEPTH - 1) begin
        mem_reg[i] <= mem_reg[i+1];
      end
    end
  end
endmodule // dsp_fifo

// File: design/dsp_port.sv
// Serial control port: shifting, decode, daisy chain, sleep, read-back
`timescale 1ns/1ns
module dsp_port #(
  parameter int ADDR_W = dsp_pkg::ADDR_W,
  parameter int DATA_W = dsp_pkg::DATA_W,
  parameter int DEPTH  = dsp_pkg::FIFO_DEPTH
) (
  // Clock and hardware reset pin
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              sdi,
  output      logic              sdo,
  output      logic              sdo_oe,
  // Control pins
  input  wire logic              wake_pin_n,
  input  wire logic              load_outputs_n,
  input  wire logic              reset_value_select,
  // Written words toward the register bank
  output      logic              wr_valid,
  input  wire logic              wr_ready,
  output      logic [ADDR_W-1:0] wr_addr,
  output      logic [DATA_W-1:0] wr_data,
  // Status
  output      logic              load_pulse,
  output      logic              strap_value,
  output      logic              port_ready,
  output      logic              sleep_mode,
  output      logic              serial_out_disable,
  output      logic              wake_by_select_enable,
  output      logic              overrun
);
  localparam int FB = dsp_pkg::FRAME_BITS;
  localparam int WW = ADDR_W + DATA_W;

  // Clean pin levels
  logic cs_s, sclk_s, sdi_s, wake_s, ld_s, strap_s;
  logic [5:0] pins_s;

  // Idle pin levels, so that no false edge follows reset
  dsp_sync #(.WIDTH(6), .RESET_VAL(6'h1b)) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({reset_value_select, load_outputs_n, wake_pin_n, sdi,
                 sclk, cs_n}),
    .level_out (pins_s)
  );
  assign {strap_s, ld_s, wake_s, sdi_s, sclk_s, cs_s} = {pins_s[5:1],
                                                        pins_s[0]};

  // State
  dsp_pkg::dsp_state_t    state_reg, state_next;
  logic                   sclk_prev_reg, cs_prev_reg, ld_prev_reg;
  logic [FB-1:0]          shift_reg, shift_next;
  logic [dsp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0]      regs_reg [2**ADDR_W];
  logic [ADDR_W-1:0]      rb_addr_reg;
  logic                   rb_pend_reg;
  logic [2:0]             boot_cnt_reg;
  logic                   sdo_next, oe_next;

  // Edges and decoded frame fields
  logic              sclk_fall, sclk_rise, cs_fall, cs_rise, ld_fall;
  logic              in_frame, frame_full, frame_short, is_read;
  logic              commit, write_ok, read_ok, wake_sel, fifo_ready;
  logic              wake_force;
  logic [ADDR_W-1:0] f_addr;
  logic [DATA_W-1:0] f_data, f_masked;
  logic [FB-1:0]     rb_word;

  // Clears the positions that hold no stored bit
  function automatic logic [DATA_W-1:0] keep_mask(
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    m = '1;
    if (a == dsp_pkg::CFG_ADDR) begin
      m[dsp_pkg::CFG_UNUSED_BIT-dsp_pkg::DATA_LO] = 1'b0;
    end
    if (a == dsp_pkg::MODE_ADDR) begin
      m = '0;
      m[dsp_pkg::MODE_SLEEP_BIT-dsp_pkg::DATA_LO] = 1'b1;
    end
    return d & m;
  endfunction

  assign sclk_fall   = sclk_prev_reg & ~sclk_s;
  assign sclk_rise   = ~sclk_prev_reg & sclk_s;
  assign cs_fall     = cs_prev_reg & ~cs_s;
  assign cs_rise     = ~cs_prev_reg & cs_s;
  assign ld_fall     = ld_prev_reg & ~ld_s;
  assign in_frame    = (state_reg == dsp_pkg::ST_FRAME);
  assign frame_full  = cnt_reg >= dsp_pkg::CNT_FULL;
  assign frame_short = ~frame_full;
  // Outside sleep, the low 24 bits hold the most recent 24 samples once 24 edges have come
  assign is_read     = shift_reg[dsp_pkg::RW_BIT];
  assign f_addr      = shift_reg[dsp_pkg::ADDR_HI:dsp_pkg::ADDR_LO];
  assign f_data      = shift_reg[dsp_pkg::DATA_HI:dsp_pkg::DATA_LO];
  assign f_masked    = keep_mask(f_addr, f_data);
  assign commit      = in_frame & cs_rise & frame_full & ~sleep_mode;
  assign read_ok     = commit & is_read;
  assign write_ok    = commit & ~is_read & fifo_ready;
  assign wake_sel    = in_frame & cs_rise & sleep_mode &
                       wake_by_select_enable &
                       (cnt_reg <= dsp_pkg::WAKE_MAX);
  assign wake_force  = ~wake_s;
  assign rb_word     = {1'b0, 2'b00, rb_addr_reg, regs_reg[rb_addr_reg],
                        4'h0};

  // Frame state: boot waits for straps, then frames follow select
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dsp_pkg::ST_BOOT: begin
        if (boot_cnt_reg == dsp_pkg::STRAP_WAIT && cs_s) begin
          state_next = dsp_pkg::ST_IDLE;
        end
      end
      dsp_pkg::ST_IDLE: begin
        if (cs_fall) begin
          state_next = dsp_pkg::ST_FRAME;
        end
      end
      dsp_pkg::ST_FRAME: begin
        if (cs_rise) begin
          state_next = dsp_pkg::ST_IDLE;
        end
      end
      default: state_next = dsp_pkg::ST_BOOT;
    endcase
  end

  // Shift register and edge counter
  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    if (state_reg == dsp_pkg::ST_IDLE && cs_fall) begin
      cnt_next = '0;
      if (rb_pend_reg) begin
        shift_next = rb_word;
      end
    end else if (in_frame && sclk_fall) begin
      if (cnt_reg != dsp_pkg::CNT_SAT) begin
        cnt_next = cnt_reg + 1'b1;
      end
      if (!sleep_mode) begin
        shift_next = {shift_reg[FB-2:0], sdi_s};
      end
    end
  end

  // Serial output data and enable
  always_comb begin
    sdo_next = sdo;
    if (state_reg == dsp_pkg::ST_IDLE && cs_fall) begin
      sdo_next = shift_next[FB-1];
    end else if (in_frame && sleep_mode) begin
      sdo_next = sdi_s;
    end else if (in_frame && sclk_rise) begin
      sdo_next = shift_reg[FB-1];
    end
  end
  assign oe_next = ~cs_s & ~serial_out_disable &
                   (state_reg != dsp_pkg::ST_BOOT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= dsp_pkg::ST_BOOT;
      sclk_prev_reg <= 1'b1;
      cs_prev_reg   <= 1'b1;
      ld_prev_reg   <= 1'b1;
      shift_reg     <= '0;
      cnt_reg       <= '0;
      sdo           <= 1'b0;
      sdo_oe        <= 1'b0;
      boot_cnt_reg  <= '0;
    end else begin
      state_reg     <= state_next;
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_s;
      ld_prev_reg   <= ld_s;
      shift_reg     <= shift_next;
      cnt_reg       <= cnt_next;
      sdo           <= sdo_next;
      sdo_oe        <= oe_next;
      if (boot_cnt_reg != dsp_pkg::STRAP_WAIT) begin
        boot_cnt_reg <= boot_cnt_reg + 1'b1;
      end
    end
  end

  // Straps are caught once, after the synchroniser has settled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_value <= 1'b0;
      port_ready  <= 1'b0;
    end else if (state_reg == dsp_pkg::ST_BOOT &&
                 state_next == dsp_pkg::ST_IDLE) begin
      strap_value <= strap_s;
      port_ready  <= 1'b1;
    end
  end

  // Configuration bits, read-back request and stored register images
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_out_disable    <= 1'b0;
      wake_by_select_enable <= 1'b0;
      sleep_mode            <= 1'b0;
      rb_addr_reg           <= '0;
      rb_pend_reg           <= 1'b0;
      load_pulse            <= 1'b0;
      overrun               <= 1'b0;
      for (int i = 0; i < 2**ADDR_W; i++) begin
        regs_reg[i] <= dsp_pkg::REG_RESET;
      end
    end else begin
      load_pulse <= ld_fall;
      overrun    <= commit & ~is_read & ~fifo_ready;
      if (state_reg == dsp_pkg::ST_IDLE && cs_fall) begin
        rb_pend_reg <= 1'b0;
      end
      if (read_ok) begin
        rb_addr_reg <= f_addr;
        rb_pend_reg <= 1'b1;
      end
      if (write_ok) begin
        regs_reg[f_addr] <= f_masked;
        if (f_addr == dsp_pkg::CFG_ADDR) begin
          serial_out_disable    <= shift_reg[dsp_pkg::CFG_SERIAL_OUT_DISABLE_BIT];
          wake_by_select_enable <= shift_reg[dsp_pkg::CFG_W2_BIT];
        end
      end
      if (wake_force || wake_sel) begin
        sleep_mode <= 1'b0;
      end else if (write_ok && f_addr == dsp_pkg::MODE_ADDR) begin
        sleep_mode <= shift_reg[dsp_pkg::MODE_SLEEP_BIT];
      end
    end
  end

  // Written words queue toward the register bank
  dsp_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (write_ok),
    .in_ready  (fifo_ready),
    .in_data   ({f_addr, f_masked}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reset_oe_off_a: assert property (disable iff (1'b0)
    !rst_n |=> !sdo_oe) else $error("sdo enabled after reset");
  idle_oe_off_a: assert property (
    cs_s |=> !sdo_oe) else $error("sdo driven with select high");
  serial_out_disable_oe_off_a: assert property (
    serial_out_disable |=> !sdo_oe)
    else $error("sdo driven while disabled");
  shift_sample_a: assert property (
    in_frame && sclk_fall && !sleep_mode
    |=> shift_reg[0] == $past(sdi_s))
    else $error("input bit not sampled");
  sleep_hold_a: assert property (
    in_frame && sclk_fall && sleep_mode |=> $stable(shift_reg))
    else $error("shift register moved in sleep");
  short_drop_a: assert property (
    cs_rise && frame_short |-> !write_ok && !read_ok)
    else $error("short frame committed");
  full_commit_a: assert property (
    in_frame && cs_rise && frame_full && !sleep_mode && !is_read
    && fifo_ready |=> wr_valid)
    else $error("full frame not queued");
  wake_pin_a: assert property (
    !wake_s |=> !sleep_mode) else $error("wake pin ignored");
  cnt_clear_a: assert property (
    state_reg == dsp_pkg::ST_IDLE && cs_fall |=> cnt_reg == '0)
    else $error("edge counter not cleared");
  pass_thru_a: assert property (
    in_frame && sleep_mode ##1 in_frame && sleep_mode
    |-> sdo == $past(sdi_s))
    else $error("pass-through broken");
  load_strobe_a: assert property (
    ld_fall |=> load_pulse) else $error("load pulse missing");

  write_cov_c: cover property (write_ok ##[1:20] wr_valid && wr_ready);
  read_cov_c:  cover property (read_ok ##[1:1000] cs_fall);
  wake_cov_c:  cover property (wake_sel);
endmodule // dsp_port

// File: dv/dsp_host.sv
// Host serial controller model that drives the port's serial pins
`timescale 1ns/1ns
module dsp_host (
  // Clock
  input  wire logic clk,
  // Serial pins
  output      logic cs_n,
  output      logic sclk,
  output      logic sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [47:0] rx_bits;

  // Select and clock stand still high between frames
  initial begin
    cs_n    = 1'b1;
    sclk    = 1'b1;
    sdi     = 1'b0;
    rx_bits = '0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Sends the low n bits of w, most significant first; one sclk fall a bit
  task automatic frame(input logic [47:0] w, input int n);
    cs_n <= 1'b0;
    wait_clk(8);
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= w[i];
      wait_clk(4);
      sclk <= 1'b0;
      wait_clk(4);
      // Line seen just before the rise that replaces it
      rx_bits <= {rx_bits[46:0], sdo_oe ? sdo : 1'bz};
      sclk    <= 1'b1;
    end
    wait_clk(8);
    cs_n <= 1'b1;
    // Released data line no longer shows the last bit
    sdi <= ~sdi;
    wait_clk(12);
  endtask
endmodule // dsp_host

// File: dv/tb_top.sv
// Self-checking bench for the converter serial control port
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst_n, wake_pin_n, load_outputs_n, reset_value_select;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, wr_valid, wr_ready;
  logic [4:0]  wr_addr;
  logic [11:0] wr_data;
  logic        load_pulse, strap_value, port_ready, sleep_mode, overrun;
  logic        serial_out_disable, wake_by_select_enable, oe_seen;
  int          miscompares, cmp_count, ovr_cnt, ld_cnt;

  dsp_port dsp_port_inst (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .wake_pin_n(wake_pin_n),
    .load_outputs_n(load_outputs_n),
    .reset_value_select(reset_value_select), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .load_pulse(load_pulse), .strap_value(strap_value),
    .port_ready(port_ready), .sleep_mode(sleep_mode),
    .serial_out_disable(serial_out_disable),
    .wake_by_select_enable(wake_by_select_enable), .overrun(overrun)
  );

  dsp_host dsp_host_inst (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (overrun === 1'b1) ovr_cnt <= ovr_cnt + 1;
    if (load_pulse === 1'b1) ld_cnt <= ld_cnt + 1;
    if (sdo_oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [23:0] w24(input logic rw, input logic [4:0] a,
                                      input logic [11:0] d);
    return {rw, 2'b00, a, d, 4'h0};
  endfunction

  task automatic send(input logic [23:0] w);
    dsp_host_inst.frame({24'h0, w}, 24);
  endtask

  task automatic wait_wr();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wr_valid !== 1'b1 && n < 40);
    check("write valid", 24'(wr_valid), 24'h1);
  endtask

  task automatic pop_any();
    wait_wr();
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
  endtask

  task automatic take(input logic [4:0] a, input logic [11:0] d);
    wait_wr();
    check("wr_addr", 24'(wr_addr), 24'(a));
    check("wr_data", 24'(wr_data), 24'(d));
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
  endtask

  task automatic expect_idle();
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      @(negedge clk);
      seen = seen | (wr_valid === 1'b1);
    end
    check("no write", 24'(seen), 24'h0);
  endtask

  task automatic t_boot();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (port_ready !== 1'b1 && n < 40);
    check("port_ready", 24'(port_ready), 24'h1);
    check("disable bit", 24'(serial_out_disable), 24'h0);
    check("sleep bit", 24'(sleep_mode), 24'h0);
    check("strap", 24'(strap_value), 24'h1);
  endtask

  task automatic t_write();
    oe_seen = 1'b0;
    dsp_host_inst.frame({24'h0, 1'b0, 2'b11, 5'h08, 12'ha5c, 4'hf}, 24);
    check("oe in frame", 24'(oe_seen), 24'h1);
    check("oe idle", 24'(sdo_oe), 24'h0);
    take(5'h08, 12'ha5c);
  endtask

  task automatic t_short();
    dsp_host_inst.frame({24'h0, w24(1'b0, 5'h09, 12'h123)}, 23);
    dsp_host_inst.frame({24'h0, w24(1'b0, 5'h09, 12'h123)}, 23);
    expect_idle();
  endtask

  task automatic t_long();
    logic [23:0] wa, wb;
    wa = w24(1'b0, 5'h0a, 12'h3c3);
    wb = w24(1'b0, 5'h0b, 12'h5a5);
    dsp_host_inst.frame({wa, wb}, 48);
    check("chain out", dsp_host_inst.rx_bits[23:0], wa);
    take(5'h0b, 12'h5a5);
    expect_idle();
  endtask

  task automatic t_read();
    send(w24(1'b0, dsp_pkg::CFG_ADDR, 12'h021));
    pop_any();
    check("wake enable", 24'(wake_by_select_enable), 24'h1);
    send(w24(1'b1, dsp_pkg::CFG_ADDR, 12'hfff));
    expect_idle();
    send(w24(1'b1, 5'h08, 12'h000));
    check("cfg read", dsp_host_inst.rx_bits[23:0],
          w24(1'b0, dsp_pkg::CFG_ADDR, 12'h001));
    send(w24(1'b1, dsp_pkg::CFG_ADDR, 12'h000));
    check("data read", dsp_host_inst.rx_bits[23:0],
          w24(1'b0, 5'h08, 12'ha5c));
  endtask

  task automatic t_sleep();
    send(w24(1'b0, dsp_pkg::MODE_ADDR, 12'h800));
    pop_any();
    check("sleep set", 24'(sleep_mode), 24'h1);
    send(w24(1'b0, 5'h0c, 12'h777));
    check("pass through", dsp_host_inst.rx_bits[23:0],
          w24(1'b0, 5'h0c, 12'h777));
    expect_idle();
    dsp_host_inst.frame(48'h0, 1);
    check("wake one edge", 24'(sleep_mode), 24'h0);
    send(w24(1'b0, dsp_pkg::MODE_ADDR, 12'h800));
    pop_any();
    dsp_host_inst.frame(48'h0, 2);
    check("two edges", 24'(sleep_mode), 24'h1);
    wake_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    wake_pin_n <= 1'b1;
    @(negedge clk);
    check("wake pin", 24'(sleep_mode), 24'h0);
  endtask

  task automatic t_fifo();
    int o;
    o = ovr_cnt;
    for (int i = 0; i < 5; i++) begin
      send(w24(1'b0, 5'h09 + 5'(i), 12'h100 + 12'(i)));
      if (i == 3) check("no overrun", 24'(ovr_cnt - o), 24'h0);
    end
    check("overrun", 24'(ovr_cnt - o), 24'h1);
    for (int i = 0; i < 4; i++) begin
      take(5'h09 + 5'(i), 12'h100 + 12'(i));
    end
    expect_idle();
  endtask

  task automatic t_disable();
    send(w24(1'b0, dsp_pkg::CFG_ADDR, 12'h004));
    pop_any();
    check("disable set", 24'(serial_out_disable), 24'h1);
    oe_seen = 1'b0;
    send(w24(1'b1, dsp_pkg::CFG_ADDR, 12'h000));
    check("oe disabled", 24'(oe_seen), 24'h0);
    // Mid-run reset must clear the disable bit again
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    check("oe in reset", 24'(sdo_oe), 24'h0);
    rst_n <= 1'b1;
    t_boot();
  endtask

  task automatic t_load();
    int l;
    l = ld_cnt;
    load_outputs_n <= 1'b0;
    repeat (12) @(posedge clk);
    load_outputs_n <= 1'b1;
    @(negedge clk);
    check("load pulse", 24'(ld_cnt - l), 24'h1);
  endtask

  initial begin
    #3_000_000;
    miscompares++;
    summarize();
  end

  initial begin
    rst_n              = 1'b0;
    wake_pin_n         = 1'b1;
    load_outputs_n     = 1'b1;
    reset_value_select = 1'b1;
    wr_ready           = 1'b0;
    oe_seen            = 1'b0;
    repeat (6) @(posedge clk);
    check("oe at reset", 24'(sdo_oe), 24'h0);
    rst_n <= 1'b1;
    t_boot();
    t_write();
    t_short();
    t_long();
    t_read();
    t_sleep();
    t_fifo();
    t_load();
    t_disable();
    summarize();
  end
endmodule // tb_top
